// ---- ecmc_pkg.sv ----
package ecmc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] CAP_LO_OFS = 5'h04;
  localparam logic [4:0] CAP_HI_OFS = 5'h08;
  localparam logic [4:0] FLAG_OFS = 5'h0C;
  localparam logic [4:0] STAT_OFS = 5'h10;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_MSB = 7;
  localparam int CFG_LSB = 6;
  localparam int DUTY_MSB = 5;
  localparam int DUTY_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 0;
  localparam int FLAG_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CAP_RST = 8'h00;

  // prescaler terminal counts
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;
  localparam logic [3:0] PRE_RST = 4'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_RSV1 = 4'h1,
    MODE_CMP_TOGGLE = 4'h2,
    MODE_RSV3 = 4'h3,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_RISE4 = 4'h6,
    MODE_CAP_RISE16 = 4'h7,
    MODE_CMP_SET = 4'h8,
    MODE_CMP_CLR = 4'h9,
    MODE_CMP_SWI = 4'hA,
    MODE_CMP_SPECIAL = 4'hB,
    MODE_PWM_HH = 4'hC,
    MODE_PWM_HL = 4'hD,
    MODE_PWM_LH = 4'hE,
    MODE_PWM_LL = 4'hF
  } ecmc_mode_e;

  typedef enum logic [2:0] {
    ROLE_PORT = 3'h0,
    ROLE_CAPCMP = 3'h1,
    ROLE_MOD = 3'h2,
    ROLE_ACTIVE = 3'h3,
    ROLE_INACTIVE = 3'h4
  } ecmc_role_e;

  typedef struct packed {
    ecmc_role_e role_d;
    ecmc_role_e role_c;
    ecmc_role_e role_b;
    ecmc_role_e role_a;
    logic pol_bd_low;
    logic pol_ac_low;
    logic use_timer2;
    logic [9:0] duty;
  } ecmc_steer_s;

  function automatic logic ecmc_is_capture(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction : ecmc_is_capture

  function automatic logic ecmc_is_compare(input logic [3:0] m);
    return (m == MODE_CMP_TOGGLE) || (m[3:2] == 2'b10);
  endfunction : ecmc_is_compare

  function automatic logic ecmc_is_pwm(input logic [3:0] m);
    return m[3:2] == 2'b11;
  endfunction : ecmc_is_pwm

endpackage : ecmc_pkg

// ---- ecmc_capture_det.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecmc_capture_det
  import ecmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic [3:0] i_mode,
  input wire logic i_clear,
  output logic o_event
);

  // ----------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic [3:0] pre_q;
  logic rise;
  logic fall;
  logic pre_hit;

  // pin level seen regardless of pin direction, so port writes count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  assign pre_hit = (i_mode == MODE_CAP_RISE4) ? (pre_q[1:0] == PRE4_LAST[1:0]) :
                   (pre_q == PRE16_LAST);

  // a direct switch between prescaled modes keeps the count on purpose
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear || !ecmc_is_capture(i_mode)) begin
      pre_q <= PRE_RST;
    end else if (rise && (i_mode[1] == 1'b1)) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      o_event <= 1'b0;
    end else begin
      unique case (i_mode)
        MODE_CAP_FALL: o_event <= fall;
        MODE_CAP_RISE: o_event <= rise;
        MODE_CAP_RISE4, MODE_CAP_RISE16: o_event <= rise & pre_hit;
        default: o_event <= 1'b0;
      endcase
    end
  end

endmodule : ecmc_capture_det
`default_nettype wire

// ---- ecmc_top.sv ----
// Summary of operation
// - writing mode zero turns unit off and returns it to reset state; here the unit flag and both capture bytes keep their values.
// - modes 0100..0111 capture on fall, rise, every 4th, every 16th rise.
// - mode 0010 toggles compare output on match and sets unit flag.
// - mode 1000 sets, 1001 clears compare output on match; both set flag.
// - mode 1010 only sets the flag on match; pin untouched.
// - mode 1011 match sets flag, resets timer1, starts conversion if enabled.
// - modes 11xx select pwm; bits 1 and 0 pick A/C and B/D polarity.
// - in pwm the config field picks single, bridge forward, half, reverse.
// - outside pwm config ignored; A is capture/compare pin, B-D port pins.
// - duty low bits join low capture byte into 10-bit duty, pwm only.
// - a capture event copies the 16-bit timer1 count into capture bytes.
// - capture sets unit flag; only software clears it.
// - a newer capture overwrites an unread one with no record.
// - edge detector watches pin level whatever its direction.
// - prescaler cleared while off, outside capture, and on reset.
// - switching prescalers keeps the count; software writes zero first.
// - capture and compare use timer1; pwm uses timer2.
// - special event at match; timer1 reset at next timer1 clock edge.
// - no overflow flag from special event; reset dropped if match lost.
// - writing zero to control forces compare output latch low.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module ecmc_top
  import ecmc_pkg::*;
#(
  parameter int unsigned ADDR_W = 5
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_CAP_PIN,
  input wire logic [15:0] I_T1_COUNT,
  input wire logic I_T1_TICK,
  input wire logic I_ADC_ENABLED,
  output logic O_CMP_OUT,
  output logic O_SPECIAL_EVENT,
  output logic O_T1_RESET,
  output logic O_ADC_START,
  output logic O_IRQ_FLAG,
  output ecmc_steer_s O_STEER
);

  // ----------------------------------------------------------------
  // decoding helper
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [4:0] w;
    w = 5'(a);
    unique case (w)
      CTRL_OFS: reg_index = 3'h0;
      CAP_LO_OFS: reg_index = 3'h1;
      CAP_HI_OFS: reg_index = 3'h2;
      FLAG_OFS: reg_index = 3'h3;
      STAT_OFS: reg_index = 3'h4;
      default: reg_index = 3'h7;
    endcase
  endfunction : reg_index

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] cap_lo_q;
  logic [7:0] cap_hi_q;
  logic flag_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held_q;
  logic do_write;
  logic [2:0] wr_idx;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_cap_lo;
  logic wr_cap_hi;
  logic wr_flag;
  logic clear_unit;
  logic [3:0] mode;
  logic cap_event;
  logic match_now;
  logic match_q;
  logic match_rise;
  logic reset_pend_q;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  ecmc_steer_s steer_d;

  assign mode = ctrl_q[MODE_MSB:MODE_LSB];

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  assign do_write = aw_held_q && w_held_q && !O_BVALID;
  assign wr_idx = reg_index(aw_addr_q);
  assign wr_lane0 = do_write && w_strb_q[0];
  assign wr_ctrl = wr_lane0 && (wr_idx == 3'h0);
  assign wr_cap_lo = wr_lane0 && (wr_idx == 3'h1);
  assign wr_cap_hi = wr_lane0 && (wr_idx == 3'h2);
  assign wr_flag = wr_lane0 && (wr_idx == 3'h3);
  assign clear_unit = wr_ctrl && (w_data_q[MODE_MSB:MODE_LSB] == MODE_OFF);

  // address and data are taken independently, in either order
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      O_AWREADY <= 1'b1;
    end else if (O_AWREADY && I_AWVALID) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= I_AWADDR;
      O_AWREADY <= 1'b0;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
      O_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      O_WREADY <= 1'b1;
    end else if (O_WREADY && I_WVALID) begin
      w_held_q <= 1'b1;
      w_data_q <= I_WDATA;
      w_strb_q <= I_WSTRB;
      O_WREADY <= 1'b0;
    end else if (do_write) begin
      w_held_q <= 1'b0;
      O_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else if (do_write) begin
      O_BVALID <= 1'b1;
      O_BRESP <= (wr_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_resp = RESP_OKAY;
    unique case (reg_index(I_ARADDR))
      3'h0: rd_data = {24'h00_0000, ctrl_q};
      3'h1: rd_data = {24'h00_0000, cap_lo_q};
      3'h2: rd_data = {24'h00_0000, cap_hi_q};
      3'h3: rd_data = {31'h0000_0000, flag_q};
      3'h4: rd_data = {29'h0000_0000, reset_pend_q, match_q, O_CMP_OUT};
      default: begin
        rd_data = 32'h0000_0000;
        rd_resp = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= RESP_OKAY;
    end else if (O_ARREADY && I_ARVALID) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= rd_data;
      O_RRESP <= rd_resp;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= w_data_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // capture path
  // ----------------------------------------------------------------
  ecmc_capture_det u_det (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_pin(I_CAP_PIN),
    .i_mode(mode),
    .i_clear(clear_unit),
    .o_event(cap_event)
  );

  // capture wins over a software write in the same cycle
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      cap_lo_q <= CAP_RST;
      cap_hi_q <= CAP_RST;
    end else if (cap_event && ecmc_is_capture(mode)) begin
      cap_lo_q <= I_T1_COUNT[7:0];
      cap_hi_q <= I_T1_COUNT[15:8];
    end else begin
      if (wr_cap_lo) begin
        cap_lo_q <= w_data_q[7:0];
      end
      if (wr_cap_hi) begin
        cap_hi_q <= w_data_q[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // compare path
  // ----------------------------------------------------------------
  assign match_now = ecmc_is_compare(mode) && (I_T1_COUNT == {cap_hi_q, cap_lo_q});
  assign match_rise = match_now && !match_q;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || clear_unit) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_now;
    end
  end

  // separate from the port data latch; low whenever unit is cleared
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || clear_unit) begin
      O_CMP_OUT <= 1'b0;
    end else if (match_rise) begin
      unique case (mode)
        MODE_CMP_TOGGLE: O_CMP_OUT <= ~O_CMP_OUT;
        MODE_CMP_SET: O_CMP_OUT <= 1'b1;
        MODE_CMP_CLR: O_CMP_OUT <= 1'b0;
        default: O_CMP_OUT <= O_CMP_OUT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // special event trigger
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || clear_unit) begin
      O_SPECIAL_EVENT <= 1'b0;
      O_ADC_START <= 1'b0;
    end else begin
      O_SPECIAL_EVENT <= match_rise && (mode == MODE_CMP_SPECIAL);
      O_ADC_START <= match_rise && (mode == MODE_CMP_SPECIAL) && I_ADC_ENABLED;
    end
  end

  // timer1 reset waits for its own clock tick; a lost match cancels it
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || clear_unit) begin
      reset_pend_q <= 1'b0;
      O_T1_RESET <= 1'b0;
    end else begin
      O_T1_RESET <= 1'b0;
      if (reset_pend_q && I_T1_TICK) begin
        reset_pend_q <= 1'b0;
        O_T1_RESET <= match_now;
      end else if (match_rise && (mode == MODE_CMP_SPECIAL)) begin
        reset_pend_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // unit flag
  // ----------------------------------------------------------------
  // no overflow flag path exists here; special event only sets this one
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      flag_q <= 1'b0;
    end else if ((cap_event && ecmc_is_capture(mode)) || match_rise) begin
      flag_q <= 1'b1;
    end else if (wr_flag) begin
      flag_q <= w_data_q[FLAG_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_IRQ_FLAG <= 1'b0;
    end else begin
      O_IRQ_FLAG <= flag_q;
    end
  end

  // ----------------------------------------------------------------
  // output steering
  // ----------------------------------------------------------------
  always_comb begin
    steer_d = '0;
    steer_d.role_a = ROLE_CAPCMP;
    steer_d.role_b = ROLE_PORT;
    steer_d.role_c = ROLE_PORT;
    steer_d.role_d = ROLE_PORT;
    if (ecmc_is_pwm(mode)) begin
      steer_d.use_timer2 = 1'b1;
      steer_d.pol_ac_low = mode[1];
      steer_d.pol_bd_low = mode[0];
      steer_d.duty = {cap_lo_q, ctrl_q[DUTY_MSB:DUTY_LSB]};
      unique case (ctrl_q[CFG_MSB:CFG_LSB])
        2'b00: begin
          steer_d.role_a = ROLE_MOD;
        end
        2'b01: begin
          steer_d.role_a = ROLE_ACTIVE;
          steer_d.role_b = ROLE_INACTIVE;
          steer_d.role_c = ROLE_INACTIVE;
          steer_d.role_d = ROLE_MOD;
        end
        2'b10: begin
          steer_d.role_a = ROLE_MOD;
          steer_d.role_b = ROLE_MOD;
        end
        2'b11: begin
          steer_d.role_a = ROLE_INACTIVE;
          steer_d.role_b = ROLE_MOD;
          steer_d.role_c = ROLE_ACTIVE;
          steer_d.role_d = ROLE_INACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_STEER <= '0;
    end else begin
      O_STEER <= steer_d;
    end
  end

endmodule : ecmc_top
`default_nettype wire

// ---- ecmc_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecmc_props
  import ecmc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_T1_TICK,
  input wire logic I_ADC_ENABLED,
  input wire logic O_SPECIAL_EVENT,
  input wire logic O_T1_RESET,
  input wire logic O_ADC_START,
  input wire logic O_IRQ_FLAG,
  input wire ecmc_steer_s O_STEER
);
  // ----
  // port relations
  // ----
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_write_answer: assert property (
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY && !O_BVALID |-> ##2 O_BVALID)
    else $error("write answer not on time");
  a_read_answer: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID) else $error("read answer not on time");
  a_bresp_stands: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP)) else $error("write answer dropped");
  a_rdata_stands: assert property (
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
  a_flag_sticky: assert property (
    $fell(O_IRQ_FLAG) |-> $past(O_BVALID)) else $error("flag cleared without a write");
  a_t1rst_tick: assert property (
    O_T1_RESET |-> $past(I_T1_TICK)) else $error("timer reset off the timer tick");
  a_adc_gated: assert property (
    O_ADC_START |-> O_SPECIAL_EVENT && $past(I_ADC_ENABLED))
    else $error("conversion start unqualified");
  a_special_flag: assert property (
    O_SPECIAL_EVENT |=> O_IRQ_FLAG) else $error("special event without flag");
  a_special_once: assert property (
    O_SPECIAL_EVENT |=> !O_SPECIAL_EVENT) else $error("special event longer than a pulse");
  a_nonpwm_ports: assert property (
    !O_STEER.use_timer2 |-> O_STEER.role_b == ROLE_PORT && O_STEER.role_c == ROLE_PORT
      && O_STEER.role_d == ROLE_PORT) else $error("outputs b to d not port pins");
endmodule : ecmc_props
`default_nettype wire

// ---- ecmc_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecmc_pin_model (
  input wire logic i_clk,
  input wire logic i_level,
  input wire logic i_slow,
  output logic o_pin
);
  // ----
  // external event source
  // ----
  // level reaches the pin after one or five cycles, so both fast and lagging sources are seen
  logic [4:0] dly_q = 5'h00;
  always_ff @(posedge i_clk) begin
    dly_q <= {dly_q[3:0], i_level};
  end
  assign o_pin = i_slow ? dly_q[4] : dly_q[0];
endmodule : ecmc_pin_model
`default_nettype wire

// ---- test_enhanced_capture_mode_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_enhanced_capture_mode_control;
  import ecmc_pkg::*;
  // ----
  // signals and model state
  // ----
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic pin_lvl = 1'b0, slow = 1'b0, t1_tick = 1'b0, adc_en = 1'b1;
  logic [15:0] t1_cnt = 16'h1234;
  logic awready, wready, bvalid, arready, rvalid, cap_pin, cmp_out, spec, t1_rst, adc_go, irq;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, rd_val;
  ecmc_steer_s steer;
  int num_errors = 0, compares = 0, n_spec = 0, n_adc = 0, n_rst = 0;
  int m_ctrl = 0, m_cap = 0, m_flag = 0, m_pre = 0, m_cmp = 0;

  always #10 clk = ~clk;

  ecmc_top ecmc_top_inst (
    .I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_CAP_PIN(cap_pin), .I_T1_COUNT(t1_cnt), .I_T1_TICK(t1_tick), .I_ADC_ENABLED(adc_en),
    .O_CMP_OUT(cmp_out), .O_SPECIAL_EVENT(spec), .O_T1_RESET(t1_rst), .O_ADC_START(adc_go),
    .O_IRQ_FLAG(irq), .O_STEER(steer));
  ecmc_pin_model ecmc_pin_model_inst (.i_clk(clk), .i_level(pin_lvl), .i_slow(slow), .o_pin(cap_pin));

  always @(posedge clk) begin
    if (spec === 1'b1) n_spec++;
    if (adc_go === 1'b1) n_adc++;
    if (t1_rst === 1'b1) n_rst++;
  end

  // ----
  // tasks
  // ----
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic hang();
    num_errors++;
    $display("[ERR] bus answer expected seen none");
    give_verdict();
  endtask : hang

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (n >= 50) hang();
    bready <= 1'b0;
    last_resp = bresp;
    if (a == CTRL_OFS) begin
      if (d[3:2] != 2'b01) m_pre = 0;
      if (d[3:0] == 4'h0) m_cmp = 0;
      m_ctrl = d;
    end
    if (a == CAP_LO_OFS) m_cap[7:0] = d;
    if (a == CAP_HI_OFS) m_cap[15:8] = d;
    if (a == FLAG_OFS) m_flag = d[0];
  endtask : wr

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rready <= 1'b0;
    chk(nm, exp, rdata);
    chk("rresp", (a > STAT_OFS) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY), 32'(rresp));
  endtask : rd_chk

  task automatic model_chk();
    rd_chk("ctrl", CTRL_OFS, 32'(m_ctrl[7:0]));
    rd_chk("cap lo", CAP_LO_OFS, 32'(m_cap[7:0]));
    rd_chk("cap hi", CAP_HI_OFS, 32'(m_cap[15:8]));
    rd_chk("flag", FLAG_OFS, 32'(m_flag));
    chk("irq", 32'(m_flag), 32'(irq));
  endtask : model_chk

  // one pin transition; timer count held so the captured value is known
  task automatic edge_to(input logic lvl, input logic [15:0] cnt);
    int md;
    md = m_ctrl[3:0];
    @(posedge clk);
    t1_cnt <= cnt;
    pin_lvl <= lvl;
    repeat (16) @(posedge clk);
    if ((md == 4 && !lvl) || (md == 5 && lvl)) begin
      m_cap = cnt;
      m_flag = 1;
    end else if ((md == 6 || md == 7) && lvl) begin
      // one shared count of rises: a direct prescaler switch keeps it
      if ((md == 6) ? (m_pre % 4 == int'(PRE4_LAST)) : (m_pre == int'(PRE16_LAST))) begin
        m_cap = cnt;
        m_flag = 1;
      end
      m_pre = (m_pre + 1) % 16;
    end
  endtask : edge_to

  task automatic pulses(input int k);
    repeat (k) begin
      edge_to(1'b1, 16'($urandom));
      edge_to(1'b0, 16'($urandom));
    end
  endtask : pulses

  task automatic hit(input logic [3:0] md);
    wr(CTRL_OFS, {4'h0, md});
    wr(FLAG_OFS, 8'h00);
    @(posedge clk);
    t1_cnt <= 16'(m_cap);
    repeat (3) @(posedge clk);
    t1_tick <= 1'b1;
    @(posedge clk);
    t1_tick <= 1'b0;
    t1_cnt <= 16'h0001;
    repeat (4) @(posedge clk);
    m_flag = 1;
    if (md == 4'h2) m_cmp = 1 - m_cmp;
    if (md == 4'h8) m_cmp = 1;
    if (md == 4'h9) m_cmp = 0;
    chk("cmp out", 32'(m_cmp), 32'(cmp_out));
    model_chk();
    rd_chk("status", STAT_OFS, 32'(m_cmp));
  endtask : hit

  function automatic logic [11:0] roles(input int c);
    case (c)
      0: return {ROLE_PORT, ROLE_PORT, ROLE_PORT, ROLE_MOD};
      1: return {ROLE_MOD, ROLE_INACTIVE, ROLE_INACTIVE, ROLE_ACTIVE};
      2: return {ROLE_PORT, ROLE_PORT, ROLE_MOD, ROLE_MOD};
      default: return {ROLE_INACTIVE, ROLE_ACTIVE, ROLE_MOD, ROLE_INACTIVE};
    endcase
  endfunction : roles

  // ----
  // main sequence
  // ----
  initial begin
    logic [7:0] d;
    ecmc_steer_s e;
    logic [3:0] cmode [4];
    int reps [4];
    logic [3:0] seq [7];
    cmode = '{4'h5, 4'h4, 4'h6, 4'h7};
    reps = '{2, 2, 5, 17};
    seq = '{4'h8, 4'h9, 4'h2, 4'h2, 4'h2, 4'hA, 4'hB};
    void'($urandom(19));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    model_chk();
    rd_chk("unmapped", 5'h14, 32'h0000_0000);
    wr(5'h14, 8'hFF);
    chk("unmapped wr", 32'(RESP_SLVERR), 32'(last_resp));
    repeat (6) begin
      d = 8'($urandom);
      if (d[3:2] == 2'b00) d[0] = 1'b0;
      wr(CTRL_OFS, d);
      rd_chk("ctrl rw", CTRL_OFS, 32'(d));
    end
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      wr(CTRL_OFS, 8'h00);
      wr(CTRL_OFS, {4'h0, cmode[i]});
      wr(FLAG_OFS, 8'h00);
      repeat (reps[i]) begin
        edge_to(1'b1, 16'($urandom));
        model_chk();
        edge_to(1'b0, 16'($urandom));
        model_chk();
      end
    end
    pulses(2);
    wr(CTRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'h06);
    wr(FLAG_OFS, 8'h00);
    pulses(3);
    model_chk();
    pulses(4);
    wr(CTRL_OFS, 8'h07);
    pulses(13);
    model_chk();
    wr(CTRL_OFS, 8'h00);
    t1_cnt <= 16'h0001;
    wr(CAP_LO_OFS, 8'h5A);
    wr(CAP_HI_OFS, 8'hC3);
    foreach (seq[i]) hit(seq[i]);
    wr(FLAG_OFS, 8'h00);
    @(posedge clk);
    adc_en <= 1'b0;
    t1_cnt <= 16'(m_cap);
    repeat (3) @(posedge clk);
    wr(CAP_LO_OFS, 8'hA5);
    @(posedge clk);
    t1_tick <= 1'b1;
    @(posedge clk);
    t1_tick <= 1'b0;
    repeat (4) @(posedge clk);
    m_flag = 1;
    model_chk();
    chk("special", 32'h0000_0002, 32'(n_spec));
    chk("adc start", 32'h0000_0001, 32'(n_adc));
    chk("t1 reset", 32'h0000_0001, 32'(n_rst));
    wr(CTRL_OFS, 8'h00);
    repeat (2) @(posedge clk);
    chk("cmp off", 32'(m_cmp), 32'(cmp_out));
    d = 8'($urandom);
    wr(CAP_LO_OFS, d);
    for (int m = 12; m < 16; m++) begin
      for (int c = 0; c < 4; c++) begin
        wr(CTRL_OFS, {2'(c), 2'($urandom), 4'(m)});
        repeat (3) @(posedge clk);
        e = {roles(c), m_ctrl[0], m_ctrl[1], 1'b1, d, m_ctrl[5:4]};
        chk("steer", 32'(e), 32'(steer));
      end
    end
    wr(CTRL_OFS, 8'hF5);
    repeat (3) @(posedge clk);
    e = {ROLE_PORT, ROLE_PORT, ROLE_PORT, ROLE_CAPCMP, 13'h0000};
    chk("ports", 32'(e[24:10]), 32'(steer[24:10]));
    wr(CTRL_OFS, 8'h00);
    give_verdict();
  end
endmodule : test_enhanced_capture_mode_control

bind ecmc_top ecmc_props ecmc_props_inst (
  .I_CLK(I_CLK),
  .I_SYS_RST(I_SYS_RST),
  .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID),
  .O_WREADY(O_WREADY),
  .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA),
  .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY),
  .I_T1_TICK(I_T1_TICK),
  .I_ADC_ENABLED(I_ADC_ENABLED),
  .O_SPECIAL_EVENT(O_SPECIAL_EVENT),
  .O_T1_RESET(O_T1_RESET),
  .O_ADC_START(O_ADC_START),
  .O_IRQ_FLAG(O_IRQ_FLAG),
  .O_STEER(O_STEER)
);
`default_nettype wire
